// ---- verilog/astx_pkg.sv ----
package astx_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam int DW = 16;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_QSLOT = 8'h10;
    localparam int CB_TX_ON = 0;
    localparam int CB_RX_ON = 1;
    localparam int CB_BREAK = 2;
    localparam int CB_NINE = 3;
    localparam int CB_OPEN_DRAIN = 4;
    localparam int CB_EMPTY_IRQ = 5;
    localparam int CB_DONE_IRQ = 6;
    localparam int CB_GPO_LEVEL = 7;
    localparam int CB_GPO_DIR = 8;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h180;
    localparam int BAUD_W = 13;
    localparam logic [BAUD_W-1:0] BAUD_RST = 13'h0000;
    localparam int SB_TX_EMPTY = 0;
    localparam int SB_TX_DONE = 1;
    localparam int SB_RX_FULL = 2;
    localparam int SB_NOISE = 3;
    localparam int SB_RX_ACTIVE = 4;
    // ****************************************
    // Frame and sample timing
    // ****************************************
    localparam int FW = 11;
    localparam logic [FW-1:0] FRAME_ONES = 11'h7ff;
    localparam logic [FW-1:0] FRAME_ZEROS = 11'h000;
    localparam logic [3:0] FLEN_8 = 4'ha;
    localparam logic [3:0] FLEN_9 = 4'hb;
    localparam logic [3:0] ONE_BIT = 4'h1;
    localparam logic [3:0] NDATA_8 = 4'h8;
    localparam logic [3:0] NDATA_9 = 4'h9;
    localparam logic [3:0] RT_LAST = 4'hf;
    localparam logic [4:0] RT_FIRST = 5'h01;
    localparam logic [4:0] RT_CHK_A = 5'h03;
    localparam logic [4:0] RT_CHK_B = 5'h05;
    localparam logic [4:0] RT_CHK_C = 5'h07;
    localparam logic [4:0] RT_VOTE_A = 5'h08;
    localparam logic [4:0] RT_VOTE_B = 5'h09;
    localparam logic [4:0] RT_VOTE_C = 5'h0a;
    localparam logic [4:0] RT_WRAP = 5'h10;
    localparam logic [2:0] HIST_MARK = 3'h7;
    localparam logic [2:0] HIST_CLR = 3'h0;

    typedef enum logic [2:0] {
        TX_IDLE, TX_PRE, TX_DATA, TX_BRK, TX_MARK
    } astx_tx_e;
    typedef enum logic [1:0] {
        RX_SEARCH, RX_CHECK, RX_FRAME
    } astx_rx_e;
endpackage

// ---- verilog/astx_bitproc.sv ----
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
// Contract
// - Holding register buffers frame while shifter sends
// - Shifter drives line while enabled or finishing
// - Open-drain select applies to serial and GPO
// - Data write loads holding, clears empty flag
// - Shifter done: move holding, set empty flag
// - Done flag low while busy; read-then-write clears
// - Enabling sends idle preamble, then sets done
// - Break sends whole zero frames while requested
// - After break: one mark bit, then done flag
// - All sent: both flags set, line marks
// - Disable finishes frames, releases pin, drops buffer
// - Quick disable/enable inserts preamble then continues
// - Interrupt request on empty or done flags
// - Preamble is 10 or 11 ones
// - Sample clock is sixteen times baud rate
// - Start needs three highs then low
// - Start checks at periods three, five, seven
// - Counter restarts on falling edge or wrap
// - Majority of periods eight-ten decides bit
// - Disagreement sets noise, reported with full flag
// - Sync held through stop, then search again
// - Receive enable starts fresh start-bit search
// - Frames of 10 or 11 bits, LSB first
// - Baud is clock over 32 times divisor
// - Stop bit moves data and sets full flag
module astx_bitproc
    import astx_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DW-1:0] o_rdata,
    input wire logic i_rxd,
    output logic o_txd_o,
    output logic o_txd_oe,
    output logic o_tx_irq
);
    // ****************************************
    // Register port
    // ****************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [BAUD_W-1:0] baud_q;
    logic [8:0] tx_hold_q;
    logic [8:0] rx_hold_q;
    logic [DW-1:0] rdata_q;
    logic tx_buf_empty_flag_q, tc_q, rx_buf_full_flag_q, noise_q, raf_q;
    logic tc_armed_q, rx_armed_q;
    logic busy, tc_vis;
    logic [DW-1:0] stat_word, rd_mux;

    wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wire wr_baud = i_wr && (i_addr == ADDR_BAUD);
    wire wr_data = i_wr && (i_addr == ADDR_DATA);
    wire wr_qslot = i_wr && (i_addr == ADDR_QSLOT);
    wire rd_stat = i_rd && (i_addr == ADDR_STAT);
    wire rd_data = i_rd && (i_addr == ADDR_DATA);
    wire tx_on = ctrl_q[CB_TX_ON];
    wire rx_on = ctrl_q[CB_RX_ON];
    wire send_break = ctrl_q[CB_BREAK];
    wire nine = ctrl_q[CB_NINE];
    wire open_drain = ctrl_q[CB_OPEN_DRAIN];

    // Done flag reads low whenever the shifter is busy
    assign tc_vis = tc_q && !busy;
    always_comb begin
        stat_word = '0;
        stat_word[SB_TX_EMPTY] = tx_buf_empty_flag_q;
        stat_word[SB_TX_DONE] = tc_vis;
        stat_word[SB_RX_FULL] = rx_buf_full_flag_q;
        stat_word[SB_NOISE] = noise_q;
        stat_word[SB_RX_ACTIVE] = raf_q;
    end
    // Unmapped addresses read as zero
    assign rd_mux = (i_addr == ADDR_CTRL) ? DW'(ctrl_q) :
                    (i_addr == ADDR_BAUD) ? DW'(baud_q) :
                    (i_addr == ADDR_STAT) ? stat_word :
                    (i_addr == ADDR_DATA) ? DW'(rx_hold_q) : '0;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RST;
            baud_q <= BAUD_RST;
            tx_hold_q <= '0;
            rdata_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= i_wdata[CTRL_W-1:0];
            if (wr_baud) baud_q <= i_wdata[BAUD_W-1:0];
            if (wr_data) tx_hold_q <= i_wdata[8:0];
            rdata_q <= i_rd ? rd_mux : '0;
        end
    end
    assign o_rdata = rdata_q;

    // ****************************************
    // Baud generator
    // ****************************************
    // Sample tick every 2*divisor clocks: 16 ticks per bit gives /32
    logic [13:0] bcnt_q;
    wire baud_off = (baud_q == BAUD_RST);
    wire [13:0] tick_at = {baud_q, 1'b0} - 14'h1;
    wire tick = !baud_off && (bcnt_q >= tick_at);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) bcnt_q <= '0;
        else if (baud_off || tick) bcnt_q <= '0;
        else bcnt_q <= bcnt_q + 14'h1;
    end

    // ****************************************
    // Transmitter
    // ****************************************
    astx_tx_e tx_st_q, nx_st;
    logic [FW-1:0] tx_sh_q, nx_sh;
    logic [3:0] tx_cnt_q, nx_cnt, tx_rt_q;
    logic ton_prev_q, pre_pend_q;

    wire [3:0] flen = nine ? FLEN_9 : FLEN_8;
    wire [FW-1:0] frame_word = nine ?
        {1'b1, tx_hold_q[8], tx_hold_q[7:0], 1'b0} :
        {2'b11, tx_hold_q[7:0], 1'b0};
    assign busy = (tx_st_q != TX_IDLE);
    wire bit_end = busy && tick && (tx_rt_q == RT_LAST);
    // Frames start only on a sample tick so bits keep full length
    wire free = (!busy && tick) || (bit_end && tx_cnt_q == ONE_BIT);
    wire ton_rise = tx_on && !ton_prev_q;

    always_comb begin
        nx_st = TX_IDLE;
        nx_sh = FRAME_ONES;
        nx_cnt = flen;
        if (tx_st_q == TX_BRK && !(send_break && tx_on)) begin
            nx_st = TX_MARK;
            nx_cnt = ONE_BIT;
        end else if (!tx_on) begin
            nx_st = TX_IDLE;
        end else if (pre_pend_q) begin
            nx_st = TX_PRE;
        end else if (send_break) begin
            nx_st = TX_BRK;
            nx_sh = FRAME_ZEROS;
        end else if (!tx_buf_empty_flag_q) begin
            nx_st = TX_DATA;
            nx_sh = frame_word;
        end
    end

    wire load_data = free && (nx_st == TX_DATA);
    wire pre_take = free && (nx_st == TX_PRE);
    wire discard = free && !tx_on;
    wire tc_set = free && busy && (tx_st_q == TX_PRE ||
        tx_st_q == TX_MARK || nx_st == TX_IDLE);
    wire tc_clr = tc_armed_q && (wr_data || wr_qslot);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= FRAME_ONES;
            tx_cnt_q <= '0;
            tx_rt_q <= '0;
        end else if (free) begin
            tx_st_q <= nx_st;
            tx_sh_q <= nx_sh;
            tx_cnt_q <= nx_cnt;
            tx_rt_q <= '0;
        end else if (bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[FW-1:1]};
            tx_cnt_q <= tx_cnt_q - ONE_BIT;
            tx_rt_q <= '0;
        end else if (busy && tick) begin
            tx_rt_q <= tx_rt_q + 4'h1;
        end
    end

    // Set wins over software clear on the done flag; a data write
    // beats the load-time empty-flag set since it leaves a fresh frame pending, but not the discard set
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ton_prev_q <= 1'b0;
            pre_pend_q <= 1'b0;
            tx_buf_empty_flag_q <= 1'b1;
            tc_q <= 1'b1;
            tc_armed_q <= 1'b0;
        end else begin
            ton_prev_q <= tx_on;
            pre_pend_q <= ton_rise || (pre_pend_q && !pre_take);
            tx_buf_empty_flag_q <= discard || (!wr_data && (load_data || tx_buf_empty_flag_q));
            tc_q <= tc_set || (tc_q && !tc_clr);
            if (tc_clr) tc_armed_q <= 1'b0;
            else if (rd_stat && tc_vis) tc_armed_q <= 1'b1;
        end
    end

    assign o_tx_irq = (tx_buf_empty_flag_q && ctrl_q[CB_EMPTY_IRQ]) ||
                      (tc_vis && ctrl_q[CB_DONE_IRQ]);

    // ****************************************
    // Transmit pin
    // ****************************************
    wire sci_drive = tx_on || busy;
    wire tx_lvl = tx_sh_q[0];
    wire pin_lvl = sci_drive ? tx_lvl : ctrl_q[CB_GPO_LEVEL];
    wire pin_en = sci_drive || ctrl_q[CB_GPO_DIR];
    // Open drain only ever pulls low; pull-up is external
    wire pin_oe_d = pin_en && (!open_drain || !pin_lvl);
    wire pin_o_d = pin_lvl && !open_drain;
    logic pin_o_q, pin_oe_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_o_q <= 1'b1;
            pin_oe_q <= 1'b1;
        end else begin
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end
    assign o_txd_o = pin_o_q;
    assign o_txd_oe = pin_oe_q;

    // ****************************************
    // Receiver bit processor
    // ****************************************
    logic rx_m_q, rx_s_q;
    astx_rx_e rx_st_q;
    logic [2:0] hist_q, chk_q;
    logic [4:0] rt_q;
    logic [3:0] rbit_q;
    logic [8:0] rsh_q;
    logic prev_q, wnoise_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= i_rxd;
            rx_s_q <= rx_m_q;
        end
    end

    wire s = rx_s_q;
    wire [4:0] rt_nx = (rt_q == RT_WRAP) ? RT_FIRST : rt_q + 5'h1;
    wire fall = prev_q && !s;
    wire [3:0] ndata = nine ? NDATA_9 : NDATA_8;
    wire two_hi = (chk_q[0] && chk_q[1]) || (chk_q[0] && s) ||
                  (chk_q[1] && s);
    wire vote = (chk_q[0] && chk_q[1]) || (chk_q[0] && s) ||
                (chk_q[1] && s);
    wire split = !((chk_q[0] == chk_q[1]) && (chk_q[1] == s));
    wire in_frame = (rx_st_q == RX_FRAME) && !fall;
    wire at_vote = tick && in_frame && (rt_nx == RT_VOTE_C);
    wire at_stop = at_vote && (rbit_q > ndata);
    wire xfer = at_stop && !rx_buf_full_flag_q;
    wire rx_clr = rx_armed_q && rd_data;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_q <= RX_SEARCH;
            hist_q <= HIST_CLR;
            chk_q <= HIST_CLR;
            rt_q <= RT_FIRST;
            rbit_q <= '0;
            rsh_q <= '0;
            prev_q <= 1'b1;
            wnoise_q <= 1'b0;
            raf_q <= 1'b0;
        end else if (!rx_on) begin
            rx_st_q <= RX_SEARCH;
            hist_q <= HIST_CLR;
            raf_q <= 1'b0;
        end else if (tick) begin
            prev_q <= s;
            if (xfer) wnoise_q <= 1'b0;
            case (rx_st_q)
                RX_SEARCH: begin
                    hist_q <= {hist_q[1:0], s};
                    if (!s && hist_q == HIST_MARK) begin
                        rt_q <= RT_FIRST;
                        raf_q <= 1'b1;
                        rx_st_q <= RX_CHECK;
                    end else if (!s && hist_q[0]) begin
                        wnoise_q <= 1'b1;
                    end
                end
                RX_CHECK: begin
                    rt_q <= rt_nx;
                    if (rt_nx == RT_CHK_A) begin
                        chk_q[0] <= s;
                    end else if (rt_nx == RT_CHK_B) begin
                        chk_q[1] <= s;
                        if (chk_q[0] && s) begin
                            wnoise_q <= 1'b1;
                            raf_q <= 1'b0;
                            hist_q <= 3'(s);
                            rx_st_q <= RX_SEARCH;
                        end
                    end else if (rt_nx == RT_CHK_C) begin
                        if (two_hi) begin
                            wnoise_q <= 1'b1;
                            raf_q <= 1'b0;
                            hist_q <= 3'(s);
                            rx_st_q <= RX_SEARCH;
                        end else begin
                            if (split) wnoise_q <= 1'b1;
                            rbit_q <= '0;
                            rx_st_q <= RX_FRAME;
                        end
                    end
                end
                RX_FRAME: begin
                    rt_q <= fall ? RT_FIRST : rt_nx;
                    if (in_frame && rt_nx == RT_VOTE_A) chk_q[0] <= s;
                    if (in_frame && rt_nx == RT_VOTE_B) chk_q[1] <= s;
                    if (at_vote) begin
                        if (split && !xfer) wnoise_q <= 1'b1;
                        rbit_q <= rbit_q + 4'h1;
                        if (rbit_q != '0 && rbit_q <= ndata) begin
                            rsh_q <= {vote, rsh_q[8:1]};
                        end
                    end
                    if (at_stop) begin
                        rx_st_q <= RX_SEARCH;
                        raf_q <= 1'b0;
                        hist_q <= {3{vote}};
                    end
                end
                default: rx_st_q <= RX_SEARCH;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_hold_q <= '0;
            rx_buf_full_flag_q <= 1'b0;
            noise_q <= 1'b0;
            rx_armed_q <= 1'b0;
        end else begin
            if (xfer) begin
                rx_hold_q <= nine ? rsh_q : {1'b0, rsh_q[8:1]};
                noise_q <= wnoise_q || split;
            end else if (rx_clr) begin
                noise_q <= 1'b0;
            end
            rx_buf_full_flag_q <= xfer || (rx_buf_full_flag_q && !rx_clr);
            if (rx_clr) rx_armed_q <= 1'b0;
            else if (rd_stat && rx_buf_full_flag_q) rx_armed_q <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_write_clears_empty: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_data |=> !tx_buf_empty_flag_q)
        else $error("Data write did not clear empty flag");
    a_idle_line_mark: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!busy && tx_on) |-> ##1 (pin_o_q || open_drain) && !pin_oe_q
            || pin_o_q)
        else $error("Idle transmitter not marking");
    a_break_zero: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (tx_st_q == TX_BRK) |-> !tx_lvl)
        else $error("Break frame sent a one");
    a_done_busy_low: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        busy |-> !stat_word[SB_TX_DONE])
        else $error("Done flag visible while busy");
    a_open_drain_pin: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(open_drain) && o_txd_oe |-> !o_txd_o)
        else $error("Open drain drove a high level");
    a_baud_stopped: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        baud_off |-> !tick)
        else $error("Baud tick with zero divisor");
    a_rt_in_range: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (rx_st_q != RX_SEARCH) |-> rt_q >= RT_FIRST && rt_q <= RT_WRAP)
        else $error("Sample counter out of range");
    a_full_after_stop: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        xfer |=> rx_buf_full_flag_q && rx_st_q == RX_SEARCH && !raf_q)
        else $error("Stop bit did not fill receive buffer");
    a_noise_with_full: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(noise_q) |-> $rose(rx_buf_full_flag_q))
        else $error("Noise flag set apart from full flag");
    a_search_raf_low: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (rx_st_q == RX_SEARCH) |-> !raf_q)
        else $error("Receiver active flag set while searching");
endmodule

// ---- dv/astx_peer.sv ----
`timescale 1ns/10ps
// ****************************************
// Far-end serial partner
// ****************************************
module astx_peer #(
    parameter int BIT_CLKS = 32
) (
    input wire logic i_mclk,
    input wire logic i_line,
    output logic o_line
);
    logic [8:0] rxq[$];
    logic [8:0] frame;

    initial begin
        o_line = 1'b1;
    end

    // Mid-bit sampling; stop level kept in bit 8 so breaks show as zero
    always begin
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_mclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge i_mclk);
            frame[i] = i_line;
        end
        rxq.push_back(frame);
        // Long break would otherwise count as many frames
        wait (i_line === 1'b1);
    end

    // Start, eight data bits LSB first, one stop bit
    task automatic send(input logic [7:0] d, input logic glitch);
        logic [9:0] bits;
        bits = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_mclk);
            o_line <= bits[i];
            if (i == 0 && glitch) begin
                // Short high spike near the fifth sample period
                repeat (8) @(posedge i_mclk);
                o_line <= 1'b1;
                repeat (2) @(posedge i_mclk);
                o_line <= 1'b0;
                repeat (BIT_CLKS - 11) @(posedge i_mclk);
            end else begin
                repeat (BIT_CLKS - 1) @(posedge i_mclk);
            end
        end
    endtask

    task automatic pulse(input int n);
        @(posedge i_mclk);
        o_line <= 1'b0;
        repeat (n) @(posedge i_mclk);
        o_line <= 1'b1;
    endtask
endmodule

// ---- dv/async_serial_tx_rx_bitproc_bench.sv ----
`timescale 1ns/10ps
module async_serial_tx_rx_bitproc_bench;
    import astx_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic mclk;
    logic rst_n;
    logic [7:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [DW-1:0] rdata;
    logic rxd;
    logic txd_o;
    logic txd_oe;
    logic tx_irq;
    int bad_count = 0;
    int compares = 0;
    // Released pin floats high through the pull-up
    wire tx_line = txd_oe ? txd_o : 1'b1;

    astx_bitproc dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_rxd(rxd), .o_txd_o(txd_o), .o_txd_oe(txd_oe),
        .o_tx_irq(tx_irq));
    astx_peer #(.BIT_CLKS(32)) far_end (.i_mclk(mclk), .i_line(tx_line),
        .o_line(rxd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk16(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [DW-1:0] m,
                          input logic [DW-1:0] exp);
        logic [DW-1:0] d;
        rd_reg(a, d);
        chk16(d & m, exp);
    endtask
    task automatic wait_stat(input int b, input logic v);
        logic [DW-1:0] s;
        rd_reg(ADDR_STAT, s);
        for (int n = 0; n < 3000 && s[b] !== v; n++) rd_reg(ADDR_STAT, s);
        chk16({15'h0000, s[b]}, {15'h0000, v});
    endtask
    task automatic wait_low(output int n);
        n = 0;
        while (tx_line !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic take_frame(input logic [8:0] exp);
        logic [8:0] f;
        for (int n = 0; n < 1500 && far_end.rxq.size() == 0; n++)
            @(posedge mclk);
        f = (far_end.rxq.size() > 0) ? far_end.rxq.pop_front() : 9'hxxx;
        chk16({7'h00, f}, {7'h00, exp});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd_chk(ADDR_STAT, 16'hffff, 16'h0003);
        rd_chk(ADDR_CTRL, 16'hffff, 16'h0180);
        rd_chk(ADDR_BAUD, 16'hffff, 16'h0000);
        rd_chk(8'h14, 16'hffff, 16'h0000);
        chk16({14'h0000, tx_line, tx_irq}, 16'h0002);
    endtask
    task automatic t_tx;
        int n;
        wr_reg(ADDR_BAUD, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0181);
        wr_reg(ADDR_DATA, 16'h00a5);
        wr_reg(ADDR_DATA, 16'h005a);
        rd_chk(ADDR_STAT, 16'h0003, 16'h0000);
        wait_low(n);
        // Ten mark bits of 32 clocks before the first start bit
        chk16(16'(n >= 300 && n <= 340), 16'h0001);
        rd_chk(ADDR_STAT, 16'h0001, 16'h0001);
        wr_reg(ADDR_DATA, 16'h003c);
        take_frame(9'h15a);
        take_frame(9'h13c);
        wait_stat(SB_TX_DONE, 1'b1);
        rd_chk(ADDR_STAT, 16'h0003, 16'h0003);
        chk16({15'h0000, tx_line}, 16'h0001);
        wr_reg(ADDR_QSLOT, 16'h0000);
        rd_chk(ADDR_STAT, 16'h0003, 16'h0001);
    endtask
    task automatic t_irq;
        wr_reg(ADDR_CTRL, 16'h01a1);
        @(posedge mclk);
        chk16({15'h0000, tx_irq}, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h01c1);
        @(posedge mclk);
        chk16({15'h0000, tx_irq}, 16'h0000);
        wr_reg(ADDR_DATA, 16'h0011);
        take_frame(9'h111);
        wait_stat(SB_TX_DONE, 1'b1);
        chk16({15'h0000, tx_irq}, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0181);
    endtask
    task automatic t_break;
        wr_reg(ADDR_CTRL, 16'h0185);
        take_frame(9'h000);
        wr_reg(ADDR_CTRL, 16'h0181);
        wait_stat(SB_TX_DONE, 1'b1);
        chk16({15'h0000, tx_line}, 16'h0001);
    endtask
    task automatic t_reenable;
        int n;
        wr_reg(ADDR_DATA, 16'h0012);
        wait_low(n);
        // Off and on again inside a frame queues a preamble after it
        wr_reg(ADDR_CTRL, 16'h0180);
        wr_reg(ADDR_CTRL, 16'h0181);
        wr_reg(ADDR_DATA, 16'h0034);
        take_frame(9'h112);
        wait_low(n);
        // Rest of the stop bit plus ten mark bits before the next start
        chk16(16'(n >= 320 && n <= 350), 16'h0001);
        take_frame(9'h134);
        wait_stat(SB_TX_DONE, 1'b1);
    endtask
    task automatic t_disable;
        int n;
        wr_reg(ADDR_DATA, 16'h0077);
        wait_low(n);
        wr_reg(ADDR_DATA, 16'h0066);
        // Port level kept high so the far end sees no false start
        wr_reg(ADDR_CTRL, 16'h0180);
        take_frame(9'h177);
        wait_stat(SB_TX_DONE, 1'b1);
        repeat (500) @(posedge mclk);
        chk16(16'(far_end.rxq.size()), 16'h0000);
        chk16({15'h0000, tx_line}, 16'h0001);
        // Pin follows the port level alone; pin register lags a clock
        wr_reg(ADDR_CTRL, 16'h0100);
        repeat (2) @(posedge mclk);
        chk16({15'h0000, tx_line}, 16'h0000);
        wr_reg(ADDR_CTRL, 16'h0190);
        repeat (2) @(posedge mclk);
        chk16({14'h0000, txd_oe, tx_line}, 16'h0001);
        wr_reg(ADDR_CTRL, 16'h0110);
        repeat (2) @(posedge mclk);
        chk16({14'h0000, txd_oe, tx_line}, 16'h0002);
    endtask
    task automatic t_rx;
        wr_reg(ADDR_CTRL, 16'h0182);
        repeat (20) @(posedge mclk);
        far_end.send(8'h3c, 1'b0);
        wait_stat(SB_RX_FULL, 1'b1);
        rd_chk(ADDR_STAT, 16'h000c, 16'h0004);
        rd_chk(ADDR_DATA, 16'h01ff, 16'h003c);
        rd_chk(ADDR_STAT, 16'h0004, 16'h0000);
        // Glitch frame right after a clean one, so only it brings noise
        far_end.send(8'hc3, 1'b1);
        wait_stat(SB_RX_FULL, 1'b1);
        rd_chk(ADDR_STAT, 16'h000c, 16'h000c);
        rd_chk(ADDR_DATA, 16'h01ff, 16'h00c3);
        // Two-tick dip is no start bit
        far_end.pulse(4);
        repeat (600) @(posedge mclk);
        rd_chk(ADDR_STAT, 16'h0014, 16'h0000);
    endtask
    // ****************************************
    // Verdict, watchdog, main sequence
    // ****************************************
    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        // All scenarios together need about 5000 clocks
        repeat (80000) @(posedge mclk);
        bad_count++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_tx();
        t_irq();
        t_break();
        t_reenable();
        t_disable();
        t_rx();
        print_verdict();
    end
endmodule
